// ---- verilog/rts_consts.svh ----
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RTS_OFF_CTRL 4'h0
`define RTS_OFF_TRANS 4'h4
`define RTS_OFF_FIRST_INTERVAL_TIMER 4'h8
`define RTS_OFF_SECOND_INTERVAL_TIMER 4'hc
`define RTS_OFF_STATUS 4'h0
// ----------------------------------------
// Control fields
// ----------------------------------------
`define RTS_CTRL_START 0
`define RTS_CTRL_HALT 1
`define RTS_CTRL_IDLE_SLEEP 2
`define RTS_CTRL_PREMAP 3
`define RTS_CTRL_GP4_LO 4
`define RTS_CTRL_GP4_HI 5
`define RTS_CTRL_BEACON 6
// ----------------------------------------
// Transition fields
// ----------------------------------------
`define RTS_TR_START_LO 0
`define RTS_TR_START_HI 1
`define RTS_TR_LPSEL 2
`define RTS_TR_IDLE 3
`define RTS_TR_RX_LO 4
`define RTS_TR_RX_HI 6
`define RTS_TR_RXTO_LO 7
`define RTS_TR_RXTO_HI 8
`define RTS_TR_TX 9
// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define RTS_START_TO_LPSEL 2'b00
`define RTS_RX_OFF_ON_PRE 3'b110
`define RTS_RX_OFF_ON_SYNC 3'b101
`define RTS_RXTO_TO_LPSEL 2'b10
`define RTS_GP4_PRE_CODE 2'b11
`define RTS_TIMER_RESET 16'h0001
// ----------------------------------------
// Timing
// ----------------------------------------
`define RTS_CLK_MHZ 50
`define RTS_TICK_NS 64000
`define RTS_TICK_CYC ((`RTS_TICK_NS * `RTS_CLK_MHZ) / 1000)
`endif

// ---- verilog/rts_pkg.sv ----
package rts_pkg;
  typedef enum logic [5:0] {
    RTS_OFF = 6'h01,
    RTS_START = 6'h02,
    RTS_LPSEL = 6'h04,
    RTS_IDLE = 6'h08,
    RTS_RX = 6'h10,
    RTS_TX = 6'h20
  } rts_state_t;
  typedef enum logic [2:0] {
    RTS_MODE_SLEEP = 3'h0,
    RTS_MODE_STBY = 3'h1,
    RTS_MODE_TX = 3'h3,
    RTS_MODE_RX = 3'h5
  } rts_mode_t;
endpackage

// ---- verilog/rts_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module rts_timer #(
  parameter int TICK_CYC = 3200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [15:0] ticks,
  output logic expired
);
  logic [15:0] tick_cnt_reg;
  logic [31:0] cyc_cnt_reg;
  logic run_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
      cyc_cnt_reg <= 32'h0000_0000;
      run_reg <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (load) begin
        tick_cnt_reg <= (ticks == 16'h0000) ? 16'h0001 : ticks;
        cyc_cnt_reg <= 32'h0000_0000;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cyc_cnt_reg == 32'(TICK_CYC - 1)) begin
          cyc_cnt_reg <= 32'h0000_0000;
          if (tick_cnt_reg == 16'h0001) begin
            run_reg <= 1'b0;
            expired <= 1'b1;
          end else begin
            tick_cnt_reg <= tick_cnt_reg - 16'h0001;
          end
        end else begin
          cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/rts_top.sv ----
// Contract
// R01: Host waits 10 ms after power-on reset before any serial access.
// R02: Host leaves external_reset_n floating during power-on reset.
// R03: Clock output starts toggling once the device is ready.
// R04: Host pulls external_reset_n low about 100 us for manual reset.
// R05: Host waits 5 ms after manual reset release before access.
// R06: Preamble listen: receive for second_interval_timer once per first_interval_timer plus second_interval_timer, else sleep.
// R07: Preamble found in listen window: sequencer off, radio stays receiving.
// R08: preamble_found drives gp_line_four when mapping is 11 and map bit set.
// R09: Sleep idle; start code 00 to low-power select; choice 1 to idle.
// R10: First_interval_timer expiry in idle goes to receive if 1, transmit if 0.
// R11: Rx codes 110/101 stop on preamble/sync; timeout code 10 to low-power.
// R12: Tx transition 0 returns to low-power select on packet_done_tx.
// R13: Sync listen: receive only for rx window, low power for rest.
// R14: Preamble before window end keeps receive until second_interval_timer end, then resumes.
// R15: Sync word match raises interrupt, stops sequencer, radio stays receiving.
// R16: Host should set first_interval_timer to its 64 us minimum for sync listen.
// R17: Packet reception during listen raises an interrupt request.
// R18: Transmitter preamble should last first_interval_timer plus twice second_interval_timer.
// R19: Beacon: transmit once per timer period, back to idle after packet_done_tx.
// R20: Beacon loops until the host sets sequencer_halt.
// R21: Beacon use needs a constant payload smaller than the FIFO.
// R22: sequencer_halt stops the sequencer at once, leaving radio mode unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module rts_top #(
  parameter int TICK_CYC = `RTS_TICK_CYC,
  parameter int RDY_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic preamble_found,
  input wire logic sync_word_match,
  input wire logic packet_done_tx,
  input wire logic payload_ready,
  input wire logic rx_window_expiry,
  input wire logic link_clk,
  output logic [2:0] radio_mode,
  output logic gp_line_four,
  output logic sync_irq,
  output logic rx_irq,
  output logic clock_output_pin,
  output var rts_pkg::rts_state_t seq_state
);
  import rts_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_reg, s2_reg, s3_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= 6'h00;
      s2_reg <= 6'h00;
      s3_reg <= 6'h00;
    end else if (ce) begin
      s1_reg <= {link_clk, rx_window_expiry, payload_ready, packet_done_tx,
                 sync_word_match, preamble_found};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic pre_s, sync_s, pdone_s, pready_s, rxto_s, lclk_rise;
  assign pre_s = s2_reg[0];
  assign sync_s = s2_reg[1];
  assign pdone_s = s2_reg[2] & ~s3_reg[2];
  assign pready_s = s2_reg[3] & ~s3_reg[3];
  assign rxto_s = s2_reg[4] & ~s3_reg[4];
  assign lclk_rise = s2_reg[5] & ~s3_reg[5];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [6:0] ctrl_reg;
  logic [9:0] trans_reg;
  logic [15:0] t1_reg, t2_reg;
  logic wr_hit, rd_pend_reg, start_pulse, halt_pulse;
  assign wr_hit = avs_write & ~avs_waitrequest;
  assign start_pulse = wr_hit & (avs_address == `RTS_OFF_CTRL) & avs_byteenable[0]
                       & avs_writedata[`RTS_CTRL_START];
  assign halt_pulse = wr_hit & (avs_address == `RTS_OFF_CTRL) & avs_byteenable[0]
                      & avs_writedata[`RTS_CTRL_HALT];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= 7'h04;
      trans_reg <= 10'h000;
      t1_reg <= `RTS_TIMER_RESET;
      t2_reg <= `RTS_TIMER_RESET;
    end else if (ce && wr_hit) begin
      unique case (avs_address)
        `RTS_OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_reg <= {avs_writedata[6:2], 2'b00};
          end
        end
        `RTS_OFF_TRANS: begin
          if (avs_byteenable[0]) begin
            trans_reg[7:0] <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            trans_reg[9:8] <= avs_writedata[9:8];
          end
        end
        `RTS_OFF_FIRST_INTERVAL_TIMER: begin
          if (avs_byteenable[0]) begin
            t1_reg[7:0] <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            t1_reg[15:8] <= avs_writedata[15:8];
          end
        end
        `RTS_OFF_SECOND_INTERVAL_TIMER: begin
          if (avs_byteenable[0]) begin
            t2_reg[7:0] <= avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            t2_reg[15:8] <= avs_writedata[15:8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Bus answer: one wait cycle, then ack
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      rd_pend_reg <= 1'b0;
    end else if (ce) begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~rd_pend_reg);
      rd_pend_reg <= (avs_read | avs_write) & avs_waitrequest & ~rd_pend_reg;
      if (avs_read && avs_waitrequest && !rd_pend_reg) begin
        unique case (avs_address)
          `RTS_OFF_CTRL: avs_readdata <= {10'h000, seq_state, 2'b00, radio_mode,
                                          4'h0, ctrl_reg[6:2], 2'b00};
          `RTS_OFF_TRANS: avs_readdata <= {22'h000000, trans_reg};
          `RTS_OFF_FIRST_INTERVAL_TIMER: avs_readdata <= {16'h0000, t1_reg};
          `RTS_OFF_SECOND_INTERVAL_TIMER: avs_readdata <= {16'h0000, t2_reg};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Interval timers
  // ----------------------------------------
  logic t1_load, t2_load, t1_exp, t2_exp;
  rts_timer #(.TICK_CYC(TICK_CYC)) u_t1 (
    .clk(clk), .rst(rst), .ce(ce), .load(t1_load), .ticks(t1_reg), .expired(t1_exp)
  );
  rts_timer #(.TICK_CYC(TICK_CYC)) u_t2 (
    .clk(clk), .rst(rst), .ce(ce), .load(t2_load), .ticks(t2_reg), .expired(t2_exp)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [2:0] rx_code;
  logic [1:0] rxto_code;
  logic pre_seen_reg;
  assign rx_code = trans_reg[`RTS_TR_RX_HI:`RTS_TR_RX_LO];
  assign rxto_code = trans_reg[`RTS_TR_RXTO_HI:`RTS_TR_RXTO_LO];
  assign t1_load = ce & (seq_state == RTS_LPSEL) & trans_reg[`RTS_TR_LPSEL];
  assign t2_load = ce & (seq_state == RTS_IDLE) & t1_exp;

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_state <= RTS_OFF;
      radio_mode <= RTS_MODE_STBY;
      pre_seen_reg <= 1'b0;
    end else if (ce) begin
      if (halt_pulse) begin
        seq_state <= RTS_OFF; // [R22] [R20]
      end else begin
        unique case (seq_state)
          RTS_OFF: begin
            if (start_pulse) begin
              seq_state <= RTS_START;
            end
          end
          RTS_START: begin
            if (trans_reg[`RTS_TR_START_HI:`RTS_TR_START_LO] == `RTS_START_TO_LPSEL) begin
              seq_state <= RTS_LPSEL; // [R09]
            end else begin
              seq_state <= RTS_OFF;
            end
          end
          RTS_LPSEL: begin
            pre_seen_reg <= 1'b0;
            if (trans_reg[`RTS_TR_LPSEL]) begin
              seq_state <= RTS_IDLE; // [R09]
              radio_mode <= ctrl_reg[`RTS_CTRL_IDLE_SLEEP] ? RTS_MODE_SLEEP
                                                           : RTS_MODE_STBY;
            end else begin
              seq_state <= RTS_OFF;
            end
          end
          RTS_IDLE: begin
            if (t1_exp) begin
              if (trans_reg[`RTS_TR_IDLE]) begin
                seq_state <= RTS_RX; // [R10] [R06]
                radio_mode <= RTS_MODE_RX;
              end else begin
                seq_state <= RTS_TX; // [R10] [R19]
                radio_mode <= RTS_MODE_TX;
              end
            end
          end
          RTS_RX: begin
            if (pre_s) begin
              pre_seen_reg <= 1'b1;
            end
            if (rx_code == `RTS_RX_OFF_ON_PRE && pre_s) begin
              seq_state <= RTS_OFF; // [R07] [R11]
            end else if (rx_code == `RTS_RX_OFF_ON_SYNC && sync_s) begin
              seq_state <= RTS_OFF; // [R15] [R11]
            end else if (rxto_code == `RTS_RXTO_TO_LPSEL && rxto_s && !pre_seen_reg
                         && !pre_s) begin
              seq_state <= RTS_LPSEL; // [R13] [R11]
            end else if (t2_exp) begin
              seq_state <= RTS_LPSEL; // [R06] [R14]
            end
          end
          RTS_TX: begin
            if (!trans_reg[`RTS_TR_TX] && pdone_s) begin
              seq_state <= RTS_LPSEL; // [R12] [R19]
            end
          end
          default: seq_state <= RTS_OFF;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  logic listen;
  assign listen = (seq_state == RTS_RX);
  always_ff @(posedge clk) begin
    if (rst) begin
      gp_line_four <= 1'b0;
      sync_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else if (ce) begin
      gp_line_four <= pre_s & ctrl_reg[`RTS_CTRL_PREMAP]
                      & (ctrl_reg[`RTS_CTRL_GP4_HI:`RTS_CTRL_GP4_LO] == `RTS_GP4_PRE_CODE); // [R08]
      sync_irq <= sync_s; // [R15]
      rx_irq <= pready_s & (listen | radio_mode == RTS_MODE_RX); // [R17]
    end
  end

  // ----------------------------------------
  // Ready clock output
  // ----------------------------------------
  logic [7:0] rdy_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_cnt_reg <= 8'h00;
      clock_output_pin <= 1'b0;
    end else if (ce && lclk_rise) begin
      if (rdy_cnt_reg == 8'(RDY_DIV)) begin
        clock_output_pin <= ~clock_output_pin; // [R03]
      end else begin
        rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  halt_stops_a: assert property (@(posedge clk) disable iff (rst) // [R22]
    (ce && halt_pulse) |=> (seq_state == RTS_OFF && $stable(radio_mode)))
    else $error("halt did not stop sequencer");
  pre_off_a: assert property (@(posedge clk) disable iff (rst) // [R07]
    (ce && seq_state == RTS_RX && rx_code == 3'b110 && pre_s && !halt_pulse)
    |=> (seq_state == RTS_OFF && radio_mode == RTS_MODE_RX))
    else $error("preamble did not stop sequencer in receive");
  sync_off_a: assert property (@(posedge clk) disable iff (rst) // [R15]
    (ce && seq_state == RTS_RX && rx_code == 3'b101 && sync_s && !halt_pulse
     && !(pre_s && rx_code == 3'b110)) |=> (seq_state == RTS_OFF && sync_irq))
    else $error("sync match did not stop sequencer");
  idle_rx_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    (ce && seq_state == RTS_IDLE && t1_exp && trans_reg[3] && !halt_pulse)
    |=> (seq_state == RTS_RX && radio_mode == RTS_MODE_RX))
    else $error("first_interval_timer expiry did not enter receive");
  idle_tx_a: assert property (@(posedge clk) disable iff (rst) // [R10]
    (ce && seq_state == RTS_IDLE && t1_exp && !trans_reg[3] && !halt_pulse)
    |=> (seq_state == RTS_TX && radio_mode == RTS_MODE_TX))
    else $error("first_interval_timer expiry did not enter transmit");
  tx_done_a: assert property (@(posedge clk) disable iff (rst) // [R12]
    (ce && seq_state == RTS_TX && !trans_reg[9] && pdone_s && !halt_pulse)
    |=> seq_state == RTS_LPSEL)
    else $error("packet done did not leave transmit");
  sleep_idle_a: assert property (@(posedge clk) disable iff (rst) // [R09]
    (ce && seq_state == RTS_LPSEL && trans_reg[2] && ctrl_reg[2] && !halt_pulse)
    |=> (seq_state == RTS_IDLE && radio_mode == RTS_MODE_SLEEP))
    else $error("idle state is not sleep");
  gp4_map_a: assert property (@(posedge clk) disable iff (rst) // [R08]
    (ce && pre_s && ctrl_reg[3] && ctrl_reg[5:4] == 2'b11) |=> gp_line_four)
    else $error("preamble not routed to line four");
endmodule
`default_nettype wire

// ---- test/rts_radio_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Radio front end: event lines and link clock
// ----------------------------------------
module rts_radio_model (
  input wire logic clk,
  output logic link_clk,
  output logic preamble_found,
  output logic sync_word_match,
  output logic packet_done_tx,
  output logic payload_ready,
  output logic rx_window_expiry
);
  initial begin
    link_clk = 1'b0;
    preamble_found = 1'b0;
    sync_word_match = 1'b0;
    packet_done_tx = 1'b0;
    payload_ready = 1'b0;
    rx_window_expiry = 1'b0;
  end
  always #80 link_clk = ~link_clk;
  // Sets one event line just after a rising edge
  task automatic drive(input int sel, input logic v);
    @(posedge clk);
    case (sel)
      0: preamble_found <= v;
      1: sync_word_match <= v;
      2: packet_done_tx <= v;
      3: payload_ready <= v;
      default: rx_window_expiry <= v;
    endcase
  endtask
  // Event pulse long enough for the two-flop synchroniser
  task automatic pulse(input int sel);
    drive(sel, 1'b1);
    repeat (4) @(posedge clk);
    drive(sel, 1'b0);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_rts_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_rts_top;
  import rts_pkg::*;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic ce = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic link_clk, preamble_found, sync_word_match, packet_done_tx, payload_ready;
  logic rx_window_expiry, gp_line_four, sync_irq, rx_irq, clock_output_pin;
  logic [2:0] radio_mode;
  rts_state_t seq_state;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int len;
  logic [31:0] rd;
  always #10 clk = ~clk;
  rts_top #(.TICK_CYC(TICK), .RDY_DIV(4)) rts_top_i (
    .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .preamble_found(preamble_found), .sync_word_match(sync_word_match),
    .packet_done_tx(packet_done_tx), .payload_ready(payload_ready),
    .rx_window_expiry(rx_window_expiry), .link_clk(link_clk), .radio_mode(radio_mode),
    .gp_line_four(gp_line_four), .sync_irq(sync_irq), .rx_irq(rx_irq),
    .clock_output_pin(clock_output_pin), .seq_state(seq_state));
  rts_radio_model rts_radio_model_i (
    .clk(clk), .link_clk(link_clk), .preamble_found(preamble_found),
    .sync_word_match(sync_word_match), .packet_done_tx(packet_done_tx),
    .payload_ready(payload_ready), .rx_window_expiry(rx_window_expiry));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_st(input rts_state_t s);
    len = 0;
    while (seq_state !== s && len < 2000) begin
      @(posedge clk);
      len++;
    end
    check("seq_state", 32'(seq_state), 32'(s));
  endtask
  // Ready shown by activity on the clock output
  task automatic wait_ready();
    len = 0;
    while (clock_output_pin === 1'b0 && len < 200) begin
      @(posedge clk);
      len++;
    end
    check("clock_output_pin_high", 32'(clock_output_pin), 32'h1);
    len = 0;
    while (clock_output_pin === 1'b1 && len < 20) begin
      @(posedge clk);
      len++;
    end
    check("clock_output_pin_low", 32'(clock_output_pin), 32'h0);
  endtask
  task automatic run(input logic [31:0] tr, input logic [15:0] t1, input logic [15:0] t2,
                     input logic [31:0] c);
    bus(1'b1, 4'h0, 32'h6);
    bus(1'b1, 4'h4, tr);
    bus(1'b1, 4'h8, {16'h0, t1});
    bus(1'b1, 4'hc, {16'h0, t2});
    bus(1'b1, 4'h0, c);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_ready();
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_reset", rd, 32'h0001_0804);
    bus(1'b0, 4'h8, 32'h0);
    check("first_interval_timer_reset", rd, 32'h1);
    avs_byteenable <= 4'h1;
    bus(1'b1, 4'hc, 32'h1234);
    avs_byteenable <= 4'hf;
    bus(1'b0, 4'hc, 32'h0);
    check("second_interval_timer_lane0", rd, 32'h0034);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    // Preamble listen
    run(32'h6c, 16'h2, 16'h3, 32'h3d);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_fields", rd & 32'h7c, 32'h3c);
    wait_st(RTS_RX);
    check("rx_mode", 32'(radio_mode), 32'(RTS_MODE_RX));
    len = 0;
    while (seq_state === RTS_RX && len < 500) begin
      @(posedge clk);
      len++;
    end
    check("rx_window", 32'(len >= 3 * TICK - 1 && len <= 3 * TICK + 4), 32'h1);
    wait_st(RTS_IDLE);
    check("idle_sleep", 32'(radio_mode), 32'(RTS_MODE_SLEEP));
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    check("ce_freeze", 32'(seq_state), 32'(RTS_IDLE));
    ce <= 1'b1;
    wait_st(RTS_RX);
    rts_radio_model_i.drive(0, 1'b1);
    wait_st(RTS_OFF);
    check("pre_stays_rx", 32'(radio_mode), 32'(RTS_MODE_RX));
    check("line_four", 32'(gp_line_four), 32'h1);
    repeat (8 * TICK) @(posedge clk);
    rts_radio_model_i.drive(0, 1'b0);
    // Sync listen
    run(32'h15c, 16'h1, 16'h14, 32'h05);
    wait_st(RTS_RX);
    rts_radio_model_i.pulse(4);
    wait_st(RTS_IDLE);
    check("rxto_fast", 32'(len < 20), 32'h1);
    check("rxto_sleep", 32'(radio_mode), 32'(RTS_MODE_SLEEP));
    wait_st(RTS_RX);
    rts_radio_model_i.drive(0, 1'b1);
    repeat (6) @(posedge clk);
    rts_radio_model_i.pulse(4);
    repeat (10) @(posedge clk);
    check("stay_rx", 32'(seq_state), 32'(RTS_RX));
    rts_radio_model_i.drive(3, 1'b1);
    len = 0;
    while (rx_irq !== 1'b1 && len < 12) begin
      @(posedge clk);
      len++;
    end
    check("rx_irq", 32'(rx_irq), 32'h1);
    rts_radio_model_i.drive(3, 1'b0);
    wait_st(RTS_IDLE);
    rts_radio_model_i.drive(0, 1'b0);
    wait_st(RTS_RX);
    rts_radio_model_i.drive(1, 1'b1);
    wait_st(RTS_OFF);
    check("sync_irq", 32'(sync_irq), 32'h1);
    check("sync_stays_rx", 32'(radio_mode), 32'(RTS_MODE_RX));
    rts_radio_model_i.drive(1, 1'b0);
    // Beacon
    run(32'h04, 16'h2, 16'h2, 32'h45);
    for (int i = 0; i < 2; i++) begin
      wait_st(RTS_TX);
      check("tx_mode", 32'(radio_mode), 32'(RTS_MODE_TX));
      rts_radio_model_i.pulse(2);
      wait_st(RTS_IDLE);
      check("beacon_idle", 32'(radio_mode), 32'(RTS_MODE_SLEEP));
    end
    wait_st(RTS_TX);
    bus(1'b1, 4'h0, 32'h46);
    repeat (2) @(posedge clk);
    check("halt_state", 32'(seq_state), 32'(RTS_OFF));
    check("halt_mode", 32'(radio_mode), 32'(RTS_MODE_TX));
    rts_radio_model_i.pulse(2);
    repeat (8) @(posedge clk);
    check("halt_holds", 32'(seq_state), 32'(RTS_OFF));
    // Manual reset in mid-run
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_ready();
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_after_reset", rd, 32'h0001_0804);
    print_verdict();
  end
endmodule
`default_nettype wire
